// ---- logic/acc_to_ctrl_reg_transfer.sv ----
// Operation
// - ext code loads aux high, acc low
// - outcfg0 transfer copies acc, acc unchanged
// - opcode 229 copies acc into outcfg1
// - outcfg2 transfer copies acc into outcfg2
// - opcode 22b copies acc into outcfg3
// - opcode 217 copies acc into intctl1
`timescale 1ns/100ps
`default_nettype none
module acc_to_ctrl_reg_transfer
  import xfer_pkg::*;
#(
  parameter logic [9:0] OP_OC0 = OP_OC0_DEF,
  parameter logic [9:0] OP_OC2 = OP_OC2_DEF
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // fetch stage
  input  wire logic               instr_valid_i,
  input  wire logic [INSTR_W-1:0] instr_i,
  input  wire logic [ACC_W-1:0]   acc_i,
  input  wire logic [ACC_W-1:0]   aux_i,
  // target registers
  output var  logic [EXT_W-1:0]   ext_reg_o,
  output var  logic [ACC_W-1:0]   outcfg0_o,
  output var  logic [ACC_W-1:0]   outcfg1_o,
  output var  logic [ACC_W-1:0]   outcfg2_o,
  output var  logic [ACC_W-1:0]   outcfg3_o,
  output var  logic [ACC_W-1:0]   intctl1_o,
  // execution status
  output var  logic               xfer_done_o,
  output var  logic               skip_req_o,
  output var  logic               carry_wr_o,
  // apb slave
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [ADDR_W-1:0]  paddr_i,
  input  wire logic [31:0]        pwdata_i,
  output var  logic [31:0]        prdata_o,
  output var  logic               pready_o,
  output var  logic               pslverr_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [NUM_SEL-1:0] sel;
  logic [NUM_SEL-1:0] load;
  logic               exec_en_ff;
  logic               hit;

  xfer_decode #(
    .OP_OC0   (OP_OC0),
    .OP_OC2   (OP_OC2)
  ) u_decode (
    .opcode_i (instr_i),
    .sel_o    (sel)
  );

  // gated by software enable; a disabled block ignores the word
  assign load = (instr_valid_i && exec_en_ff) ? sel : '0;
  assign hit  = |load;

  // ---------------------------------------------------------------
  // target registers
  // ---------------------------------------------------------------
  logic [ACC_W-1:0] cfg_q [4];

  xfer_reg #(
    .WIDTH     (EXT_W),
    .RST       (EXT_RST)
  ) u_ext (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (load[SEL_EXT]),
    .d_i       ({aux_i, acc_i}),
    .q_o       (ext_reg_o)
  );

  // acc is only read here, so it stays untouched
  for (genvar g = 0; g < 4; g++) begin : g_cfg
    xfer_reg #(
      .WIDTH     (ACC_W),
      .RST       (CFG_RST)
    ) u_cfg (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .load_i    (load[SEL_OC0+g]),
      .d_i       (acc_i),
      .q_o       (cfg_q[g])
    );
  end

  assign outcfg0_o = cfg_q[0];
  assign outcfg1_o = cfg_q[1];
  assign outcfg2_o = cfg_q[2];
  assign outcfg3_o = cfg_q[3];

  xfer_reg #(
    .WIDTH     (ACC_W),
    .RST       (INT1_RST)
  ) u_int1 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .load_i    (load[SEL_INT1]),
    .d_i       (acc_i),
    .q_o       (intctl1_o)
  );

  // ---------------------------------------------------------------
  // execution status
  // ---------------------------------------------------------------
  logic               done_ff;
  logic               nxt_done;
  logic [NUM_SEL-1:0] last_sel_ff;
  logic [NUM_SEL-1:0] nxt_last_sel;
  logic [CNT_W-1:0]   cnt_ff;
  logic [CNT_W-1:0]   nxt_cnt;

  always_comb begin
    nxt_done     = hit;
    nxt_last_sel = last_sel_ff;
    nxt_cnt      = cnt_ff;
    if (hit) begin
      nxt_last_sel = load;
      nxt_cnt      = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_ff     <= 1'b0;
      last_sel_ff <= '0;
      cnt_ff      <= '0;
    end else begin
      done_ff     <= nxt_done;
      last_sel_ff <= nxt_last_sel;
      cnt_ff      <= nxt_cnt;
    end
  end

  // these transfers never touch carry or request a skip
  logic skip_ff;
  logic carry_wr_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      skip_ff     <= 1'b0;
      carry_wr_ff <= 1'b0;
    end else begin
      skip_ff     <= 1'b0;
      carry_wr_ff <= 1'b0;
    end
  end

  assign xfer_done_o = done_ff;
  assign skip_req_o  = skip_ff;
  assign carry_wr_o  = carry_wr_ff;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // one wait-free access: data prepared in setup, ready in access
  logic        ready_ff;
  logic        nxt_ready;
  logic        err_ff;
  logic        nxt_err;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        nxt_exec_en;
  logic        setup;
  logic        mapped;
  logic        wr_ctrl;

  assign setup   = psel_i && !penable_i;
  assign mapped  = (paddr_i == OFF_CTRL) || (paddr_i == OFF_STATUS) ||
                   (paddr_i == OFF_EXT) || (paddr_i == OFF_OUTCFG) ||
                   (paddr_i == OFF_INTCTL);
  assign wr_ctrl = psel_i && penable_i && ready_ff && pwrite_i && (paddr_i == OFF_CTRL);

  always_comb begin
    nxt_ready   = setup;
    nxt_err     = setup && !mapped;
    nxt_rdata   = rdata_ff;
    nxt_exec_en = exec_en_ff;
    if (setup) begin
      nxt_rdata = 32'h0000_0000;
      if (!pwrite_i) begin
        case (paddr_i)
          OFF_CTRL:   nxt_rdata[CTRL_EN_BIT] = exec_en_ff;
          OFF_STATUS: begin
            nxt_rdata[NUM_SEL-1:0]                  = last_sel_ff;
            nxt_rdata[ST_CNT_LSB+CNT_W-1:ST_CNT_LSB] = cnt_ff;
          end
          OFF_EXT:    nxt_rdata[EXT_W-1:0] = ext_reg_o;
          OFF_OUTCFG: nxt_rdata[15:0] = {cfg_q[3], cfg_q[2], cfg_q[1], cfg_q[0]};
          OFF_INTCTL: nxt_rdata[ACC_W-1:0] = intctl1_o;
          default:    nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_ctrl) begin
      nxt_exec_en = pwdata_i[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_ff   <= 1'b0;
      err_ff     <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      exec_en_ff <= CTRL_EN_RST;
    end else begin
      ready_ff   <= nxt_ready;
      err_ff     <= nxt_err;
      rdata_ff   <= nxt_rdata;
      exec_en_ff <= nxt_exec_en;
    end
  end

  assign pready_o  = ready_ff;
  assign pslverr_o = err_ff;
  assign prdata_o  = rdata_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic go;
  assign go = instr_valid_i && exec_en_ff;

  AST_EXT_LOAD: assert property (
    go && instr_i == OP_EXT |=> ext_reg_o == {$past(aux_i), $past(acc_i)})
    else $error("ext register not loaded from aux and acc");

  AST_OC0_LOAD: assert property (
    go && instr_i == OP_OC0 |=> outcfg0_o == $past(acc_i) && $stable(outcfg1_o))
    else $error("outcfg0 not loaded from acc");

  AST_OC1_LOAD: assert property (
    go && instr_i == OP_OC1 |=> outcfg1_o == $past(acc_i) && $stable(outcfg0_o))
    else $error("outcfg1 not loaded from acc");

  AST_OC2_LOAD: assert property (
    go && instr_i == OP_OC2 |=> outcfg2_o == $past(acc_i) && $stable(outcfg3_o))
    else $error("outcfg2 not loaded from acc");

  AST_OC3_LOAD: assert property (
    go && instr_i == OP_OC3 |=> outcfg3_o == $past(acc_i) && $stable(outcfg2_o))
    else $error("outcfg3 not loaded from acc");

  AST_INT1_LOAD: assert property (
    go && instr_i == OP_INT1 |=> intctl1_o == $past(acc_i) && $stable(ext_reg_o))
    else $error("intctl1 not loaded from acc");

  AST_ONE_CYCLE: assert property (
    hit ##1 !hit |-> xfer_done_o ##1 !xfer_done_o)
    else $error("transfer did not complete in one cycle");

  AST_NO_SIDE: assert property (
    xfer_done_o |-> !skip_req_o && !carry_wr_o)
    else $error("transfer touched carry or skip");

  AST_IDLE_HOLD: assert property (
    !go |=> $stable(ext_reg_o) && $stable(intctl1_o) && !xfer_done_o)
    else $error("target changed without a transfer");

  // load checks other than the ext one see their own target and one neighbour; these catch stray writes elsewhere
  AST_CFG_HOLD: assert property (
    !go |=> $stable(outcfg0_o) && $stable(outcfg1_o) &&
            $stable(outcfg2_o) && $stable(outcfg3_o))
    else $error("outcfg register changed without a transfer");

  AST_FOREIGN_OP: assert property (
    go && !(|sel) |=> !xfer_done_o && $stable(ext_reg_o) && $stable(outcfg0_o))
    else $error("code outside the group changed state");

  AST_EXT_ONLY: assert property (
    go && instr_i == OP_EXT |=> $stable(outcfg0_o) && $stable(intctl1_o))
    else $error("ext transfer touched another target");

  AST_DONE_ON_HIT: assert property (
    hit |=> xfer_done_o)
    else $error("accepted transfer gave no done pulse");

  AST_APB_READY: assert property (
    psel_i && !penable_i |=> pready_o)
    else $error("no ready in the first access cycle");

  AST_APB_ERR: assert property (
    psel_i && !penable_i |=> pslverr_o == !$past(mapped))
    else $error("slave error does not match the address map");

  COV_EXT:  cover property (go && instr_i == OP_EXT ##1 xfer_done_o);
  COV_BACK: cover property (hit ##1 hit ##1 hit);
  COV_OFF:  cover property (instr_valid_i && !exec_en_ff && |sel);
  COV_ERR:  cover property (pready_o && pslverr_o);
  COV_DIS:  cover property (wr_ctrl && !pwdata_i[CTRL_EN_BIT]);

endmodule
`default_nettype wire

// ---- logic/xfer_decode.sv ----
`timescale 1ns/100ps
`default_nettype none
module xfer_decode
  import xfer_pkg::*;
#(
  parameter logic [9:0] OP_OC0 = OP_OC0_DEF,
  parameter logic [9:0] OP_OC2 = OP_OC2_DEF
) (
  // instruction
  input  wire logic [INSTR_W-1:0] opcode_i,
  // one-hot target
  output var  logic [NUM_SEL-1:0] sel_o
);

  // full 10-bit compare: near neighbours in the set must not alias
  always_comb begin
    sel_o           = '0;
    sel_o[SEL_EXT]  = (opcode_i == OP_EXT);
    sel_o[SEL_OC0]  = (opcode_i == OP_OC0);
    sel_o[SEL_OC1]  = (opcode_i == OP_OC1);
    sel_o[SEL_OC2]  = (opcode_i == OP_OC2);
    sel_o[SEL_OC3]  = (opcode_i == OP_OC3);
    sel_o[SEL_INT1] = (opcode_i == OP_INT1);
  end

endmodule
`default_nettype wire

// ---- logic/xfer_pkg.sv ----
package xfer_pkg;

  // ---------------------------------------------------------------
  // instruction word
  // ---------------------------------------------------------------
  localparam int          INSTR_W  = 10;
  localparam int          ACC_W    = 4;
  localparam int          EXT_W    = 8;
  localparam logic [9:0]  OP_EXT   = 10'h01a;
  localparam logic [9:0]  OP_OC1   = 10'h229;
  localparam logic [9:0]  OP_OC3   = 10'h22b;
  localparam logic [9:0]  OP_INT1  = 10'h217;
  // defaults only: top-level parameters carry the real values
  localparam logic [9:0]  OP_OC0_DEF = 10'h228;
  localparam logic [9:0]  OP_OC2_DEF = 10'h22a;

  // ---------------------------------------------------------------
  // target select vector
  // ---------------------------------------------------------------
  localparam int          SEL_EXT  = 0;
  localparam int          SEL_OC0  = 1;
  localparam int          SEL_OC1  = 2;
  localparam int          SEL_OC2  = 3;
  localparam int          SEL_OC3  = 4;
  localparam int          SEL_INT1 = 5;
  localparam int          NUM_SEL  = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  EXT_RST  = 8'h00;
  localparam logic [3:0]  CFG_RST  = 4'h0;
  localparam logic [3:0]  INT1_RST = 4'h0;

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_STATUS  = 12'h004;
  localparam logic [11:0] OFF_EXT     = 12'h008;
  localparam logic [11:0] OFF_OUTCFG  = 12'h00c;
  localparam logic [11:0] OFF_INTCTL  = 12'h010;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int          ST_CNT_LSB  = 8;
  localparam int          CNT_W       = 8;

endpackage

// ---- logic/xfer_reg.sv ----
`timescale 1ns/100ps
`default_nettype none
module xfer_reg
  import xfer_pkg::*;
#(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // load
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] d_i,
  // value
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (load_i) begin
      nxt_q = d_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule
`default_nettype wire

// ---- tb/acc_to_ctrl_reg_transfer_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module acc_to_ctrl_reg_transfer_tb_top
  import xfer_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        ref_clk_i;
  logic        rst_i;
  logic        instr_valid_i;
  logic [9:0]  instr_i;
  logic [3:0]  acc_i;
  logic [3:0]  aux_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  ext_reg_o;
  logic [3:0]  outcfg0_o;
  logic [3:0]  outcfg1_o;
  logic [3:0]  outcfg2_o;
  logic [3:0]  outcfg3_o;
  logic [3:0]  intctl1_o;
  logic        xfer_done_o;
  logic        skip_req_o;
  logic        carry_wr_o;

  // ---------------------------------------------------------------
  // reference model state
  // ---------------------------------------------------------------
  int          errors;
  int          tests_run;
  logic [31:0] seed;
  int          m_ext;
  int          m_cfg [4];
  int          m_int;
  int          m_cnt;
  int          m_last;
  bit          m_en;
  logic        p_v;
  logic [9:0]  p_op;
  logic [3:0]  p_acc;
  logic [3:0]  p_aux;
  // last entry is a code outside the group
  logic [9:0]  ops [7] = '{OP_EXT, OP_OC0_DEF, OP_OC1, OP_OC2_DEF, OP_OC3, OP_INT1, 10'h3ff};

  acc_to_ctrl_reg_transfer uut (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst_i),
    .instr_valid_i (instr_valid_i),
    .instr_i       (instr_i),
    .acc_i         (acc_i),
    .aux_i         (aux_i),
    .ext_reg_o     (ext_reg_o),
    .outcfg0_o     (outcfg0_o),
    .outcfg1_o     (outcfg1_o),
    .outcfg2_o     (outcfg2_o),
    .outcfg3_o     (outcfg3_o),
    .intctl1_o     (intctl1_o),
    .xfer_done_o   (xfer_done_o),
    .skip_req_o    (skip_req_o),
    .carry_wr_o    (carry_wr_o),
    .psel_i        (psel_i),
    .penable_i     (penable_i),
    .pwrite_i      (pwrite_i),
    .paddr_i       (paddr_i),
    .pwdata_i      (pwdata_i),
    .prdata_o      (prdata_o),
    .pready_o      (pready_o),
    .pslverr_o     (pslverr_o)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one cycle: retire the word driven last cycle, drive the next one
  task automatic step(input logic v, input logic [9:0] op);
    logic [31:0] r;
    int          k;
    int          done;
    r = rnd();
    @(posedge ref_clk_i);
    done = 0;
    for (k = 0; k < 6; k++) begin
      if (p_v && m_en && p_op === ops[k]) begin
        done = 1;
        m_last = 1 << k;
        m_cnt = (m_cnt + 1) % 256;
        if (k == 0)
          m_ext = {p_aux, p_acc};
        else if (k == 5)
          m_int = p_acc;
        else
          m_cfg[k-1] = p_acc;
      end
    end
    p_v = v;
    p_op = op;
    p_acc = r[3:0];
    p_aux = r[7:4];
    instr_valid_i <= v;
    instr_i <= op;
    acc_i <= r[3:0];
    aux_i <= r[7:4];
    @(negedge ref_clk_i);
    chk(ext_reg_o, m_ext, "ext");
    chk(outcfg0_o, m_cfg[0], "outcfg0");
    chk(outcfg1_o, m_cfg[1], "outcfg1");
    chk(outcfg2_o, m_cfg[2], "outcfg2");
    chk(outcfg3_o, m_cfg[3], "outcfg3");
    chk(intctl1_o, m_int, "intctl1");
    chk(xfer_done_o, done, "done");
    chk({skip_req_o, carry_wr_o}, 0, "skip_carry");
  endtask

  // apb master: waits for pready, then checks that it came after exactly one access cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk(n, 1, "pready_wait");
  endtask

  task automatic rchk(input logic [11:0] a, input int exp, input logic eerr, input string nm);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h00000000, rd, er);
    chk(rd, exp, nm);
    chk(er, eerr, nm);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #50000;
    errors++;
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    logic        er;
    int          i;
    {rst_i, instr_valid_i, instr_i, acc_i, aux_i} = {1'b1, 19'h00000};
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 47'h0;
    errors = 0;
    tests_run = 0;
    m_ext = 0;
    m_int = 0;
    m_cnt = 0;
    m_last = 0;
    m_cfg = '{0, 0, 0, 0};
    m_en = 1'b1;
    p_v = 1'b0;
    seed = 32'h000031fc;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    step(1'b0, 10'h000);
    rchk(OFF_CTRL, 1, 1'b0, "ctrl_rst");
    // every code back to back, then a random mix
    for (i = 0; i < 7; i++) step(1'b1, ops[i]);
    for (i = 0; i < 60; i++) begin
      r = rnd();
      step(r[8] | r[9], ops[r[2:0] % 7]);
    end
    step(1'b0, 10'h000);
    rchk(OFF_STATUS, (m_cnt << 8) | m_last, 1'b0, "status");
    rchk(OFF_EXT, m_ext, 1'b0, "ext_rd");
    rchk(OFF_OUTCFG, (m_cfg[3] << 12) | (m_cfg[2] << 8) | (m_cfg[1] << 4) | m_cfg[0],
         1'b0, "outcfg_rd");
    rchk(OFF_INTCTL, m_int, 1'b0, "intctl_rd");
    rchk(12'h014, 0, 1'b1, "unmapped");
    // read-only place must ignore the write
    apb(1'b1, OFF_EXT, 32'h000000ff, r, er);
    chk(er, 0, "ext_ro_err");
    rchk(OFF_EXT, m_ext, 1'b0, "ext_ro");
    // execution disabled: every word refused
    apb(1'b1, OFF_CTRL, 32'h00000000, r, er);
    m_en = 1'b0;
    rchk(OFF_CTRL, 0, 1'b0, "ctrl_off");
    for (i = 0; i < 6; i++) step(1'b1, ops[i]);
    step(1'b0, 10'h000);
    apb(1'b1, OFF_CTRL, 32'h00000001, r, er);
    m_en = 1'b1;
    step(1'b1, OP_OC3);
    step(1'b0, 10'h000);
    // mid-run reset: targets clear, enable returns to its reset value
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    m_ext = 0;
    m_int = 0;
    m_cnt = 0;
    m_last = 0;
    m_cfg = '{0, 0, 0, 0};
    step(1'b0, 10'h000);
    rchk(OFF_STATUS, 0, 1'b0, "status_rst");
    rchk(OFF_CTRL, 1, 1'b0, "ctrl_rst2");
    step(1'b1, OP_EXT);
    step(1'b0, 10'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
